/* File: logic/sfc_pkg.sv */
// Constants, types and state layout of the serial flash host controller
package sfc_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_MHZ      = 125;
    localparam int unsigned SCLK_HALF_NS = 32;
    localparam int unsigned SCLK_HALF_CY = (SCLK_HALF_NS * CLK_MHZ + 999) / 1000;
    localparam logic [2:0]  SCLK_HALF_M1 = 3'(SCLK_HALF_CY - 1);

    // ------------------------------------------------------------------
    // Register map (byte offsets) and reset values
    // ------------------------------------------------------------------
    localparam logic [7:0]  OFS_CTRL = 8'h00;
    localparam logic [7:0]  OFS_ADDR = 8'h04;
    localparam logic [7:0]  OFS_STAT = 8'h08;
    localparam logic [7:0]  OFS_RXLO = 8'h0C;
    localparam logic [7:0]  OFS_RXHI = 8'h10;
    localparam logic [3:0]  LEN_RST  = 4'h2;
    localparam logic [3:0]  IO_IDLE  = 4'hC;

    // ------------------------------------------------------------------
    // Opcodes and frame figures
    // ------------------------------------------------------------------
    localparam logic [7:0]  OP_MFR   = 8'h90;
    localparam logic [7:0]  OP_DUAL  = 8'h92;
    localparam logic [7:0]  OP_QUAD  = 8'h94;
    localparam logic [7:0]  OP_UID   = 8'h4B;
    localparam logic [7:0]  OP_JEDEC = 8'h9F;
    localparam logic [7:0]  OP_SFDP  = 8'h5A;
    localparam logic [7:0]  OP_ERASE = 8'h44;
    localparam logic [7:0]  OP_WREN  = 8'h06;
    localparam logic [7:0]  OP_RDSR  = 8'h05;
    localparam logic [7:0]  MODE_VAL = 8'hF0;
    localparam logic [6:0]  OP_BITS  = 7'h08;
    localparam logic [6:0]  AD_BITS  = 7'h18;
    localparam logic [6:0]  MD_BITS  = 7'h08;
    localparam logic [6:0]  QD_DUMMY = 7'h04;
    localparam logic [6:0]  UI_DUMMY = 7'h20;
    localparam logic [6:0]  SF_DUMMY = 7'h08;
    localparam logic [6:0]  UI_BITS  = 7'h40;
    localparam logic [6:0]  JD_BITS  = 7'h18;
    localparam logic [6:0]  SR_BITS  = 7'h08;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        CMD_MFR, CMD_DUAL, CMD_QUAD, CMD_UID, CMD_JEDEC,
        CMD_SFDP, CMD_ERASE, CMD_WREN, CMD_RDSR
    } sfc_cmd_e;
    typedef enum logic [2:0] {ST_IDLE, ST_LEAD, ST_XFER, ST_TAIL, ST_GAP} sfc_st_e;
    typedef enum logic [2:0] {PH_OP, PH_ADDR, PH_MODE, PH_DUMMY, PH_DATA} sfc_ph_e;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
    } sfc_apb_req_s;
    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } sfc_apb_rsp_s;
    typedef struct packed {
        logic       cs_n;
        logic       sclk;
        logic [3:0] io_out;
        logic [3:0] io_oe;
    } sfc_spi_s;
    typedef struct packed {
        logic [7:0]  op;
        logic [23:0] ad;
        logic [6:0]  abits;
        logic [6:0]  mbits;
        logic [6:0]  dclk;
        logic [6:0]  dbits;
        logic [1:0]  lwa;
        logic [1:0]  lwd;
    } sfc_plan_s;
    typedef struct packed {
        sfc_st_e      st;
        sfc_ph_e      ph;
        sfc_cmd_e     cmd;
        sfc_cmd_e     job;
        logic [2:0]   div;
        logic [6:0]   bits;
        logic [1:0]   lw;
        logic [39:0]  tx;
        logic [63:0]  rx;
        logic [23:0]  addr;
        logic [3:0]   len;
        logic         busy;
        logic         done;
        logic         err;
        logic [7:0]   sr;
        logic [3:0]   sy1;
        logic [3:0]   sy2;
        sfc_plan_s    pl;
        sfc_apb_rsp_s apb;
        sfc_spi_s     spi;
    } sfc_state_s;

endpackage

/* File: logic/sfc_flash_host.sv */
// Host controller issuing ID, parameter and secure-area erase commands to a serial flash
`timescale 1ns/1ps
`default_nettype none

module sfc_flash_host (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire sfc_pkg::sfc_apb_req_s apb_i,
    output var  sfc_pkg::sfc_apb_rsp_s apb_o,
    input  wire logic [3:0]            spi_io_in,
    output var  sfc_pkg::sfc_spi_s     spi_o
);
    import sfc_pkg::*;

    sfc_state_s s_r;
    sfc_state_s s_nxt;

    // ------------------------------------------------------------------
    // Frame plan per command
    // ------------------------------------------------------------------
    function automatic sfc_plan_s plan_of(input sfc_cmd_e c, input logic [23:0] a,
                                          input logic [3:0] len);
        sfc_plan_s  p;
        logic [3:0] lb;
        p  = '0;
        lb = (len == 4'h0 || len > 4'h8) ? 4'h8 : len;
        unique case (c)
            CMD_MFR: begin
                p.op    = OP_MFR;
                p.abits = AD_BITS;
                p.dbits = {lb, 3'b000};
            end
            CMD_DUAL: begin
                p.op    = OP_DUAL;
                p.abits = AD_BITS;
                p.mbits = MD_BITS;
                p.lwa   = 2'd1;
                p.lwd   = 2'd1;
                p.dbits = {lb, 3'b000};
            end
            CMD_QUAD: begin
                p.op    = OP_QUAD;
                p.abits = AD_BITS;
                p.mbits = MD_BITS;
                p.dclk  = QD_DUMMY;
                p.lwa   = 2'd2;
                p.lwd   = 2'd2;
                p.dbits = {lb, 3'b000};
            end
            CMD_UID: begin
                p.op    = OP_UID;
                p.dclk  = UI_DUMMY;
                p.dbits = UI_BITS;
            end
            CMD_JEDEC: begin
                p.op    = OP_JEDEC;
                p.dbits = JD_BITS;
            end
            CMD_SFDP: begin
                p.op    = OP_SFDP;
                p.ad    = {16'h0000, a[7:0]};
                p.abits = AD_BITS;
                p.dclk  = SF_DUMMY;
                p.dbits = {lb, 3'b000};
            end
            CMD_ERASE: begin
                p.op    = OP_ERASE;
                p.ad    = {8'h00, 2'b00, a[1:0], 4'h0, 8'h00};
                p.abits = AD_BITS;
            end
            CMD_WREN: begin
                p.op    = OP_WREN;
            end
            CMD_RDSR: begin
                p.op    = OP_RDSR;
                p.dbits = SR_BITS;
            end
            default: p = '0;
        endcase
        return p;
    endfunction

    // ------------------------------------------------------------------
    // Lane drive for a phase and width
    // ------------------------------------------------------------------
    function automatic logic [7:0] drive_of(input sfc_ph_e ph, input logic [1:0] lw,
                                            input logic [39:0] tx, input logic quad);
        logic [7:0] d;
        d = {IO_IDLE, IO_IDLE};
        unique case (ph)
            PH_OP:   d = {4'b1101, 3'b110, tx[39]};
            PH_ADDR,
            PH_MODE: begin
                unique case (lw)
                    2'd1:    d = {4'b1111, 2'b11, tx[39:38]};
                    2'd2:    d = {4'b1111, tx[39:36]};
                    default: d = {4'b1101, 3'b110, tx[39]};
                endcase
            end
            // Quad frames free the hold/protect lanes for device data
            PH_DUMMY,
            PH_DATA: d = quad ? {4'b0000, IO_IDLE} : {IO_IDLE, IO_IDLE};
        endcase
        return d;
    endfunction

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic       acc;
        logic       launch;
        sfc_cmd_e   lcmd;
        logic [6:0] step;
        logic       last;
        logic [7:0] dr;
        sfc_cmd_e   wc;
        s_nxt  = s_r;
        acc    = 1'b0;
        launch = 1'b0;
        lcmd   = CMD_WREN;
        step   = 7'd1;
        last   = 1'b0;
        dr     = '0;
        wc     = sfc_cmd_e'(apb_i.pwdata[3:0]);

        // Pin inputs pass two flops before anything reads them
        s_nxt.sy1 = spi_io_in;
        s_nxt.sy2 = s_r.sy1;

        // APB setup: prepare answer, ready in access cycle
        s_nxt.apb.pready  = 1'b0;
        s_nxt.apb.pslverr = 1'b0;
        if (apb_i.psel && !apb_i.penable) begin
            s_nxt.apb.pready = 1'b1;
            s_nxt.apb.prdata = '0;
            unique case (apb_i.paddr[7:0])
                OFS_CTRL: s_nxt.apb.prdata = {20'h0, s_r.len, 4'h0, s_r.job};
                OFS_ADDR: s_nxt.apb.prdata = {8'h00, s_r.addr};
                OFS_STAT: s_nxt.apb.prdata = {16'h0, s_r.sr, 5'h0, s_r.err, s_r.done,
                                              s_r.busy};
                OFS_RXLO: s_nxt.apb.prdata = s_r.rx[31:0];
                OFS_RXHI: s_nxt.apb.prdata = s_r.rx[63:32];
                default:  s_nxt.apb.pslverr = 1'b1;
            endcase
            if (apb_i.paddr[31:8] != 24'h0) begin
                s_nxt.apb.pslverr = 1'b1;
            end
        end
        acc = apb_i.psel && apb_i.penable && s_r.apb.pready && apb_i.pwrite;

        // Register writes; ignored while a job runs
        if (acc && !s_r.busy && !s_r.apb.pslverr) begin
            if (apb_i.paddr[7:0] == OFS_ADDR) begin
                s_nxt.addr = apb_i.pwdata[23:0];
            end
            if (apb_i.paddr[7:0] == OFS_CTRL) begin
                s_nxt.job  = wc;
                s_nxt.len  = apb_i.pwdata[11:8];
                s_nxt.done = 1'b0;
                s_nxt.err  = 1'b0;
                if (apb_i.pwdata[3:0] > 4'(CMD_RDSR)) begin
                    s_nxt.err  = 1'b1;
                    s_nxt.done = 1'b1;
                end else if (wc == CMD_ERASE && s_r.addr[1:0] == 2'b00) begin
                    s_nxt.err  = 1'b1;
                    s_nxt.done = 1'b1;
                end else if (wc == CMD_ERASE) begin
                    s_nxt.busy = 1'b1;
                    launch     = 1'b1;
                    lcmd       = CMD_WREN;
                end else begin
                    s_nxt.busy = 1'b1;
                    launch     = 1'b1;
                    lcmd       = wc;
                end
            end
        end

        // Frame engine
        unique case (s_r.st)
            ST_IDLE: begin
            end
            ST_LEAD: begin
                s_nxt.div = s_r.div + 3'd1;
                if (s_r.div == SCLK_HALF_M1) begin
                    s_nxt.div = 3'd0;
                    s_nxt.st  = ST_XFER;
                end
            end
            ST_XFER: begin
                s_nxt.div = s_r.div + 3'd1;
                if (s_r.div == SCLK_HALF_M1) begin
                    s_nxt.div = 3'd0;
                    if (!s_r.spi.sclk) begin
                        s_nxt.spi.sclk = 1'b1;
                    end else begin
                        s_nxt.spi.sclk = 1'b0;
                        step = 7'd1 << s_r.lw;
                        // Late in the high half the device bit is settled
                        if (s_r.ph == PH_DATA) begin
                            unique case (s_r.lw)
                                2'd1:    s_nxt.rx = {s_r.rx[61:0], s_r.sy2[1:0]};
                                2'd2:    s_nxt.rx = {s_r.rx[59:0], s_r.sy2};
                                default: s_nxt.rx = {s_r.rx[62:0], s_r.sy2[1]};
                            endcase
                        end
                        unique case (s_r.lw)
                            2'd1:    s_nxt.tx = {s_r.tx[37:0], 2'b00};
                            2'd2:    s_nxt.tx = {s_r.tx[35:0], 4'h0};
                            default: s_nxt.tx = {s_r.tx[38:0], 1'b0};
                        endcase
                        s_nxt.bits = s_r.bits - step;
                        last = (s_r.bits <= step);
                        if (last) begin
                            if (s_r.ph == PH_OP && s_r.pl.abits != 7'd0) begin
                                s_nxt.ph   = PH_ADDR;
                                s_nxt.bits = s_r.pl.abits;
                                s_nxt.lw   = s_r.pl.lwa;
                            end else if (s_r.ph == PH_ADDR && s_r.pl.mbits != 7'd0) begin
                                s_nxt.ph   = PH_MODE;
                                s_nxt.bits = s_r.pl.mbits;
                            end else if (s_r.ph != PH_DUMMY && s_r.ph != PH_DATA
                                         && s_r.pl.dclk != 7'd0) begin
                                s_nxt.ph   = PH_DUMMY;
                                s_nxt.bits = s_r.pl.dclk;
                                s_nxt.lw   = 2'd0;
                            end else if (s_r.ph != PH_DATA && s_r.pl.dbits != 7'd0) begin
                                s_nxt.ph   = PH_DATA;
                                s_nxt.bits = s_r.pl.dbits;
                                s_nxt.lw   = s_r.pl.lwd;
                            end else begin
                                s_nxt.st = ST_TAIL;
                            end
                        end
                        dr = drive_of(s_nxt.ph, s_nxt.lw, s_nxt.tx, s_r.pl.lwd == 2'd2);
                        s_nxt.spi.io_oe  = dr[7:4];
                        s_nxt.spi.io_out = dr[3:0];
                    end
                end
            end
            ST_TAIL: begin
                s_nxt.div = s_r.div + 3'd1;
                if (s_r.div == SCLK_HALF_M1) begin
                    s_nxt.div        = 3'd0;
                    s_nxt.spi.cs_n   = 1'b1;
                    s_nxt.spi.io_oe  = IO_IDLE;
                    s_nxt.spi.io_out = IO_IDLE;
                    s_nxt.st         = ST_GAP;
                end
            end
            ST_GAP: begin
                s_nxt.div = s_r.div + 3'd1;
                if (s_r.div == SCLK_HALF_M1) begin
                    s_nxt.div = 3'd0;
                    s_nxt.st  = ST_IDLE;
                    if (s_r.cmd == CMD_RDSR) begin
                        s_nxt.sr = s_r.rx[7:0];
                    end
                    // Erase job: enable, erase, then poll busy until clear
                    if (s_r.job == CMD_ERASE && s_r.cmd == CMD_WREN) begin
                        launch = 1'b1;
                        lcmd   = CMD_ERASE;
                    end else if (s_r.job == CMD_ERASE && s_r.cmd == CMD_ERASE) begin
                        launch = 1'b1;
                        lcmd   = CMD_RDSR;
                    end else if (s_r.job == CMD_ERASE && s_r.rx[0]) begin
                        launch = 1'b1;
                        lcmd   = CMD_RDSR;
                    end else begin
                        s_nxt.busy = 1'b0;
                        s_nxt.done = 1'b1;
                    end
                end
            end
            default: s_nxt.st = ST_IDLE;
        endcase

        // Frame start: select low, opcode MSB on lane 0
        if (launch) begin
            s_nxt.cmd      = lcmd;
            s_nxt.pl       = plan_of(lcmd, acc ? apb_i.pwdata[23:0] & 24'h0 | s_r.addr
                                           : s_r.addr, s_nxt.len);
            s_nxt.tx       = {s_nxt.pl.op, s_nxt.pl.ad, MODE_VAL};
            s_nxt.st       = ST_LEAD;
            s_nxt.ph       = PH_OP;
            s_nxt.bits     = OP_BITS;
            s_nxt.lw       = 2'd0;
            s_nxt.div      = 3'd0;
            s_nxt.spi.cs_n = 1'b0;
            s_nxt.spi.sclk = 1'b0;
            dr = drive_of(PH_OP, 2'd0, s_nxt.tx, 1'b0);
            s_nxt.spi.io_oe  = dr[7:4];
            s_nxt.spi.io_out = dr[3:0];
            if (lcmd != CMD_RDSR) begin
                s_nxt.rx = '0;
            end
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r            <= '0;
            s_r.len        <= LEN_RST;
            s_r.spi.cs_n   <= 1'b1;
            s_r.spi.io_out <= IO_IDLE;
            s_r.spi.io_oe  <= IO_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from the state flops
    assign apb_o = s_r.apb;
    assign spi_o = s_r.spi;

endmodule

`default_nettype wire

/* File: verification/sfc_host_checker.sv */
// Port-level assertions for the serial flash host controller
`timescale 1ns/1ps
`default_nettype none
module sfc_host_checker (
    input wire logic                  pclk,
    input wire logic                  presetn,
    input wire sfc_pkg::sfc_apb_req_s apb_i,
    input wire sfc_pkg::sfc_apb_rsp_s apb_o,
    input wire logic [3:0]            spi_io_in,
    input wire sfc_pkg::sfc_spi_s     spi_o
);
    import sfc_pkg::*;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Bus answer: one wait-free access cycle, one-cycle pulse
    a_pready_answer: assert property (apb_i.psel && !apb_i.penable |=> apb_o.pready)
        else $error("pready missing after setup");
    a_pready_pulse: assert property (apb_o.pready |=> !apb_o.pready)
        else $error("pready held longer than one cycle");
    a_slverr_rdy: assert property (apb_o.pslverr |-> apb_o.pready)
        else $error("pslverr without pready");
    a_unmapped_err: assert property (apb_i.psel && !apb_i.penable && apb_i.paddr[31:8] != 24'h0
        |=> apb_o.pslverr) else $error("unmapped access not refused");

    // Link timing: lead, half period, outputs steady while the device samples
    a_lead_low: assert property ($fell(spi_o.cs_n) |-> !spi_o.sclk [*8] ##1 spi_o.sclk)
        else $error("select lead time wrong");
    a_high_half: assert property ($rose(spi_o.sclk) |-> spi_o.sclk [*4] ##1 !spi_o.sclk)
        else $error("clock high half wrong");
    a_hold_high: assert property (spi_o.sclk |-> $stable(spi_o.io_out) && $stable(spi_o.io_oe))
        else $error("lane changed while clock high");
    a_idle_lines: assert property (spi_o.cs_n |-> !spi_o.sclk && spi_o.io_oe == IO_IDLE)
        else $error("idle link not quiet");
    a_gap_min: assert property ($rose(spi_o.cs_n) |-> spi_o.cs_n [*4])
        else $error("deselect gap too short");

    // Main scenarios reached
    c_frame: cover property ($fell(spi_o.cs_n));
    c_refused: cover property (apb_o.pslverr);
    c_quad_in: cover property (!spi_o.cs_n && spi_o.io_oe == 4'h0);
endmodule
`default_nettype wire

/* File: verification/sfc_flash_model.sv */
// Behavioural serial flash device answering the host controller's frames
`timescale 1ns/1ps
`default_nettype none
module sfc_flash_model #(
    parameter logic [7:0]  MAKER    = 8'h5C,                  // Arbitrary identity value
    parameter logic [7:0]  DEV_ID   = 8'h15,                  // Arbitrary identity value
    parameter logic [7:0]  MEM_TYPE = 8'h40,
    parameter logic [7:0]  CAPACITY = 8'h16,
    parameter logic [63:0] UID      = 64'h0123_4567_89AB_CDEF, // Fixed, no write path
    parameter logic [2:0]  LOCKS    = 3'h4,
    parameter int          ERASE_NS = 3000
) (
    input  wire logic       cs_n,
    input  wire logic       sclk,
    input  wire logic [3:0] io,
    output var  logic [3:0] dev_io
);
    logic [7:0]  op = 8'h00;
    logic [23:0] addr = 24'h0;
    logic        write_enable_latch = 1'b0;
    logic        busy = 1'b0;
    logic [2:0]  erased = 3'h0; // Three separate areas
    logic [1:0]  sel;
    int          cnt = 0;
    int          mode_bad = 0;
    int          lead;
    int          w;

    // Data bit p of the answer stream for the current opcode
    function automatic logic bit_at(int p);
        logic [7:0] b;
        b = ((p / 8) % 2) ? DEV_ID : MAKER;
        case (op)
            8'h9F: b = (p < 8) ? MAKER : (p < 16) ? MEM_TYPE : CAPACITY;
            8'h5A: b = 8'hA5 ^ (addr[7:0] + 8'(p / 8));
            8'h05: b = {6'h0, write_enable_latch, busy};
            default: ;
        endcase
        return (op == 8'h4B) ? UID[63 - (p % 64)] : b[7 - (p % 8)];
    endfunction

    // Frame start clears the shift state
    always @(negedge cs_n) begin
        cnt = 0;
        op = 8'h00;
        addr = 24'h0;
    end

    // Opcode and address taken on rising clock edges; mode nibble checked
    always @(posedge sclk) begin
        if (!cs_n) begin
            if (cnt < 8)
                op = {op[6:0], io[0]};
            else if (cnt < 32)
                addr = {addr[22:0], io[0]};
            if ((op == 8'h92 && (cnt == 20 || cnt == 21) && io[1:0] !== 2'h3) ||
                (op == 8'h94 && cnt == 14 && io !== 4'hF))
                mode_bad = mode_bad + 1;
            cnt = cnt + 1;
        end
    end

    // Answer driven on falling edges once the lead-in clocks have passed
    always @(negedge sclk) begin
        if (!cs_n) begin
            case (op)
                8'h90: lead = 32;
                8'h92: lead = 24;
                8'h94: lead = 20;
                8'h4B, 8'h5A: lead = 40;
                8'h9F, 8'h05: lead = 8;
                default: lead = 1000;
            endcase
            w = (op == 8'h92) ? 2 : (op == 8'h94) ? 4 : 1;
            if (cnt >= lead)
                for (int i = 0; i < w; i++)
                    dev_io[(w == 1) ? 1 : w - 1 - i] = bit_at((cnt - lead) * w + i);
        end
    end

    // Released lanes show the inverse of the last value, never a held level
    always @(posedge cs_n)
        dev_io = ~dev_io;

    // Write enable and self-timed erase; this process sleeps through the erase
    always @(posedge cs_n) begin
        sel = addr[13:12] - 2'h1;
        if (op == 8'h06 && cnt == 8)
            write_enable_latch = 1'b1;
        if (op == 8'h44 && cnt == 32 && write_enable_latch && addr[23:16] == 8'h0 && addr[11:8] == 4'h0 &&
            addr[15:12] inside {4'h1, 4'h2, 4'h3} && !LOCKS[sel]) begin
            busy = 1'b1;
            #ERASE_NS;
            erased[sel] = 1'b1;
            busy = 1'b0;
            write_enable_latch = 1'b0;
        end
    end

    initial
        dev_io = 4'h5;
endmodule
`default_nettype wire

/* File: verification/tb.sv */
// Self-checking bench for the serial flash host controller
`timescale 1ns/1ps
`default_nettype none
module tb;
    import sfc_pkg::*;
    localparam logic [7:0]  MAKER = 8'h5C;                 // Arbitrary identity value
    localparam logic [7:0]  DEV_ID = 8'h15;                // Arbitrary identity value
    localparam logic [7:0]  MEM_TYPE = 8'h40;
    localparam logic [7:0]  CAPACITY = 8'h16;
    localparam logic [63:0] UID = 64'h0123_4567_89AB_CDEF; // Arbitrary value

    logic         pclk;
    logic         presetn;
    sfc_apb_req_s apb_i;
    sfc_apb_rsp_s apb_o;
    sfc_spi_s     spi_o;
    logic [3:0]   dev_io;
    logic [3:0]   io_wire;
    int           failures;
    int           total_checks;
    logic [31:0]  rd;
    logic         err;

    // Each lane carries whichever party enables it
    assign io_wire = (spi_o.io_oe & spi_o.io_out) | (~spi_o.io_oe & dev_io);

    sfc_flash_host sfc_flash_host_inst (.pclk(pclk), .presetn(presetn), .apb_i(apb_i),
        .apb_o(apb_o), .spi_io_in(io_wire), .spi_o(spi_o));
    sfc_flash_model #(.MAKER(MAKER), .DEV_ID(DEV_ID), .MEM_TYPE(MEM_TYPE),
        .CAPACITY(CAPACITY), .UID(UID)) sfc_flash_model_inst (.cs_n(spi_o.cs_n),
        .sclk(spi_o.sclk), .io(io_wire), .dev_io(dev_io));

    // Verdict and end of run
    task automatic stop_test();
        if (failures == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One APB transfer; request held until pready is sampled high
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        apb_i <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {24'h0, a}, pwdata: d};
        @(posedge pclk);
        apb_i.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (apb_o.pready !== 1'b1 && n < 50);
        if (apb_o.pready !== 1'b1) begin
            failures++;
            stop_test();
        end
        rd = apb_o.prdata;
        err = apb_o.pslverr;
        apb_i.psel <= 1'b0;
        apb_i.penable <= 1'b0;
    endtask

    // Start a job and poll status until done with busy clear
    task automatic run_job(input logic [3:0] cmd, input logic [3:0] len, input logic [23:0] adr);
        int n;
        xfer(1'b1, OFS_ADDR, {8'h0, adr});
        xfer(1'b1, OFS_CTRL, {20'h0, len, 4'h0, cmd});
        n = 0;
        do begin
            xfer(1'b0, OFS_STAT, 32'h0);
            n++;
        end while (rd[1:0] !== 2'h2 && n < 2000);
        if (rd[1:0] !== 2'h2) begin
            failures++;
            stop_test();
        end
    endtask

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // Main sequence
    initial begin
        logic [3:0]  cmds [4];
        logic [3:0]  lens [4];
        logic [31:0] exps [4];
        cmds = '{4'h0, 4'h1, 4'h2, 4'h4};
        lens = '{4'h2, 4'h4, 4'h4, 4'h3};
        exps = '{{16'h0, MAKER, DEV_ID}, {MAKER, DEV_ID, MAKER, DEV_ID},
                 {MAKER, DEV_ID, MAKER, DEV_ID}, {8'h0, MAKER, MEM_TYPE, CAPACITY}};
        presetn = 1'b0;
        apb_i = '0;
        failures = 0;
        total_checks = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        xfer(1'b0, OFS_CTRL, 32'h0);
        check("ctrl reset", 32'h0000_0200, rd);
        xfer(1'b0, OFS_STAT, 32'h0);
        check("stat reset", 32'h0, rd);
        xfer(1'b1, 8'h14, 32'hFFFF_FFFF);
        check("unmapped err", 32'h1, {31'h0, err});
        for (int i = 0; i < 4; i++) begin
            run_job(cmds[i], lens[i], 24'h0);
            xfer(1'b0, OFS_RXLO, 32'h0);
            check("id word", exps[i], rd);
        end
        check("mode bits", 32'h0, 32'(sfc_flash_model_inst.mode_bad));
        run_job(4'h3, 4'h8, 24'h0);
        xfer(1'b0, OFS_RXHI, 32'h0);
        check("uid high", UID[63:32], rd);
        xfer(1'b0, OFS_RXLO, 32'h0);
        check("uid low", UID[31:0], rd);
        run_job(4'h5, 4'h3, 24'h0000FE);
        xfer(1'b0, OFS_RXLO, 32'h0);
        check("table bytes", {8'h0, 8'hA5 ^ 8'hFE, 8'hA5 ^ 8'hFF, 8'hA5}, rd);
        xfer(1'b0, OFS_ADDR, 32'h0);
        check("addr reg", 32'h0000_00FE, rd);
        run_job(4'h9, 4'h1, 24'h0);
        check("bad cmd", 32'h0000_0006, rd & 32'h0000_0007);
        run_job(4'h6, 4'h1, 24'h2);
        check("erase stat", 32'h0000_0002, rd);
        check("erased", 32'h2, {29'h0, sfc_flash_model_inst.erased});
        run_job(4'h6, 4'h1, 24'h3);
        check("locked stat", 32'h0000_0202, rd);
        check("locked", 32'h2, {29'h0, sfc_flash_model_inst.erased});
        run_job(4'h6, 4'h1, 24'h0);
        check("bad select", 32'h4, rd & 32'h4);
        run_job(4'h6, 4'h1, 24'h1);
        check("erased one", 32'h3, {29'h0, sfc_flash_model_inst.erased});
        run_job(4'h8, 4'h1, 24'h0);
        check("latch clear", 32'h0000_0002, rd);
        run_job(4'h7, 4'h1, 24'h0);
        run_job(4'h8, 4'h1, 24'h0);
        check("latch set", 32'h0000_0202, rd);
        stop_test();
    end
endmodule

bind sfc_flash_host sfc_host_checker sfc_host_checker_inst (.pclk(pclk), .presetn(presetn),
    .apb_i(apb_i), .apb_o(apb_o), .spi_io_in(spi_io_in), .spi_o(spi_o));
`default_nettype wire
